/* pdcs_defs.svh */
// offsets, field positions, reset values and fixed patterns of the bank
`ifndef PDCS_DEFS_SVH
`define PDCS_DEFS_SVH
// configuration offsets (dword aligned access, byte lanes pick halves)
`define PDCS_OFF_DEV_CTL      8'h78
`define PDCS_OFF_DEV_STS      8'h7a
`define PDCS_OFF_LINK_CAP     8'h7c
// device control field positions
`define PDCS_CTL_FRT_BIT      15
`define PDCS_CTL_RRS_HI       14
`define PDCS_CTL_RRS_LO       12
`define PDCS_CTL_PFE_BIT      9
// device status field positions
`define PDCS_STS_OUTSTANDING_REQUEST_FLAG_BIT     5
`define PDCS_STS_AUX_BIT      4
// link capability field positions
`define PDCS_LCAP_L1_LO       15
`define PDCS_LCAP_L0S_LO      12
// reset values
`define PDCS_CTL_RESET        16'h2810
`define PDCS_LCAP_FIXED       32'h0004_0c12
`define PDCS_LCAP_L1_DEF      3'h6
`define PDCS_L0S_ASYNC_DEF    3'h1
`define PDCS_L0S_COMMON_DEF   3'h3
`endif

/* pdcs_pkg.sv */
// types shared by the device control and status bank
package pdcs_pkg;
  // live copy of the device control fields
  typedef struct packed {
    logic [2:0] read_request_size_limit;
    logic       no_snoop_enable;
    logic       aux_power_pm_enable;
    logic       extended_tag_enable;
    logic [2:0] payload_size_limit;
    logic       relaxed_ordering_enable;
    logic       unsupported_request_report_enable;
    logic       fatal_error_report_enable;
    logic       nonfatal_error_report_enable;
    logic       correctable_error_report_enable;
  } pdcs_ctl_s;
  // error events, bit order as in the status register
  typedef struct packed {
    logic unsupported_request_detected;
    logic fatal_error_detected;
    logic nonfatal_error_detected;
    logic correctable_error_detected;
  } pdcs_err_s;
endpackage : pdcs_pkg

/* pdcs_regs.sv */
// device control, device status and link capability registers
`timescale 1ns/10ps
`include "pdcs_defs.svh"
module pdcs_regs #(
  parameter logic [2:0] L1_LAT_ASYNC   = `PDCS_LCAP_L1_DEF,
  parameter logic [2:0] L1_LAT_COMMON  = `PDCS_LCAP_L1_DEF,
  parameter logic [2:0] L0S_LAT_ASYNC  = `PDCS_L0S_ASYNC_DEF,
  parameter logic [2:0] L0S_LAT_COMMON = `PDCS_L0S_COMMON_DEF
) (
  // clock, global reset, enable
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // configuration access from the root complex side
  input  wire logic              cfg_req,
  input  wire logic              cfg_we,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic                   cfg_ack,
  output logic [31:0]            cfg_rdata,
  // core events, same clock
  input  pdcs_pkg::pdcs_err_s    err_event,
  input  wire logic              np_issue,
  input  wire logic              np_done,
  input  wire logic              tlp_vc_nonzero,
  input  wire logic              common_clock_config,
  // aux power sense pin, asynchronous
  input  wire logic              aux_power_sense_pin,
  // control outputs
  output pdcs_pkg::pdcs_ctl_s    ctl_out,
  output logic                   function_reset,
  output logic [12:0]            read_limit_bytes,
  output logic                   tlp_no_snoop_attr
);

  // ****************************************************************
  // storage
  // ****************************************************************
  pdcs_pkg::pdcs_ctl_s ctl_ff;        // control fields
  pdcs_pkg::pdcs_err_s err_ff;        // sticky error flags
  logic [8:0]          outstanding_request_flag_cnt_ff;   // open requests, room for 256 tags
  logic                aux_s1_ff;     // sync stage one, read only by s2
  logic                aux_s2_ff;     // synchronised sense level
  logic [2:0]          l1_lat_ff;     // selected l1 exit latency
  logic [2:0]          l0s_lat_ff;    // selected l0s exit latency
  logic                frt_ff;        // function reset pulse
  logic                ack_ff;        // access answer
  logic [31:0]         rdata_ff;      // read data
  logic [12:0]         rlim_ff;       // request size cap in bytes
  logic                nsa_ff;        // no snoop attribute

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic hit_ctl   = cfg_req && (cfg_addr == `PDCS_OFF_DEV_CTL);
  wire logic hit_lcap  = cfg_req && (cfg_addr == `PDCS_OFF_LINK_CAP);
  wire logic wr_lo     = hit_ctl && cfg_we && cfg_be[0];
  wire logic wr_hi     = hit_ctl && cfg_we && cfg_be[1];
  wire logic wr_sts    = hit_ctl && cfg_we && cfg_be[2];
  // trigger bit only acts on a write of one
  wire logic frt_hit   = wr_hi && cfg_wdata[`PDCS_CTL_FRT_BIT];
  // function reset clears function state, global reset clears all
  wire logic func_clr  = frt_ff;
  wire logic outstanding_request_flag_flag = (outstanding_request_flag_cnt_ff != 9'h000);
  // control reset image; bits 15 and 9 have no storage behind them
  wire logic [15:0] ctl_rst16 = `PDCS_CTL_RESET;
  wire pdcs_pkg::pdcs_ctl_s ctl_rst = {ctl_rst16[14:10],
                                       ctl_rst16[8:0]};

  // control register image as software reads it
  wire logic [15:0] ctl_rd = {1'b0,
    ctl_ff.read_request_size_limit, ctl_ff.no_snoop_enable,
    ctl_ff.aux_power_pm_enable, 1'b0,
    ctl_ff.extended_tag_enable, ctl_ff.payload_size_limit,
    ctl_ff.relaxed_ordering_enable,
    ctl_ff.unsupported_request_report_enable,
    ctl_ff.fatal_error_report_enable,
    ctl_ff.nonfatal_error_report_enable,
    ctl_ff.correctable_error_report_enable};
  // status image, upper bits reserved
  wire logic [15:0] sts_rd = {10'h000, outstanding_request_flag_flag,
                              aux_s2_ff, err_ff};
  // link capability image, built from fixed bits and latencies
  wire logic [31:0] lcap_rd = `PDCS_LCAP_FIXED
    | ({29'h0, l1_lat_ff} << `PDCS_LCAP_L1_LO)
    | ({29'h0, l0s_lat_ff} << `PDCS_LCAP_L0S_LO);
  wire logic [31:0] rd_mux = hit_ctl  ? {sts_rd, ctl_rd} :
                             hit_lcap ? lcap_rd : 32'h0000_0000;
  // write data mapped onto the control fields
  wire logic [15:0] wd = cfg_wdata[15:0];
  // reserved size codes clamp to the largest legal size
  wire logic [2:0] rrs = ctl_ff.read_request_size_limit;
  wire logic [12:0] rlim_nxt = (rrs > 3'h5) ? 13'h1000
                             : 13'(13'h0080 << rrs);
  wire pdcs_pkg::pdcs_err_s err_clr = wr_sts ? cfg_wdata[19:16] : 4'h0;
  // set wins over a clear in the same cycle
  wire pdcs_pkg::pdcs_err_s nxt_err = (err_ff & ~err_clr)
                                      | err_event;

  // ****************************************************************
  // control register
  // ****************************************************************
  // aux pm enable only sees the global reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctl_ff <= ctl_rst;
    end else if (clk_en) begin
      if (func_clr) begin
        // reset image, but the aux pm enable survives
        ctl_ff <= {ctl_rst16[14:11], ctl_ff.aux_power_pm_enable,
                   ctl_rst16[8:0]};
      end else begin
        if (wr_hi) begin
          ctl_ff.read_request_size_limit <= wd[14:12];
          ctl_ff.no_snoop_enable         <= wd[11];
          ctl_ff.aux_power_pm_enable     <= wd[10];
          ctl_ff.extended_tag_enable     <= wd[8];
        end
        if (wr_lo) begin
          ctl_ff.payload_size_limit      <= wd[7:5];
          ctl_ff.relaxed_ordering_enable <= wd[4];
          ctl_ff.unsupported_request_report_enable <= wd[3];
          ctl_ff.fatal_error_report_enable         <= wd[2];
          ctl_ff.nonfatal_error_report_enable      <= wd[1];
          ctl_ff.correctable_error_report_enable   <= wd[0];
        end
      end
    end
  end

  // ****************************************************************
  // status flags, pending count, aux sync
  // ****************************************************************
  // flags and counter are function state, so a function reset clears them
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      err_ff      <= '0;
      outstanding_request_flag_cnt_ff <= 9'h000;
      aux_s1_ff   <= 1'b0;
      aux_s2_ff   <= 1'b0;
    end else if (clk_en) begin
      err_ff      <= func_clr ? '0 : nxt_err;
      aux_s1_ff   <= aux_power_sense_pin;
      aux_s2_ff   <= aux_s1_ff;
      // wide enough for every tag, so a full tag space never wraps to zero
      if (func_clr)
        outstanding_request_flag_cnt_ff <= 9'h000;
      else if (np_issue && !np_done)
        outstanding_request_flag_cnt_ff <= outstanding_request_flag_cnt_ff + 9'h001;
      else if (np_done && !np_issue && outstanding_request_flag_flag)
        outstanding_request_flag_cnt_ff <= outstanding_request_flag_cnt_ff - 9'h001;
    end
  end

  // ****************************************************************
  // link capabilities, access answer, derived outputs
  // ****************************************************************
  // latencies track the common clock bit; no write path exists at all
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      l1_lat_ff  <= `PDCS_LCAP_L1_DEF;
      l0s_lat_ff <= `PDCS_L0S_ASYNC_DEF;
      frt_ff     <= 1'b0;
      ack_ff     <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rlim_ff    <= 13'h0200;
      nsa_ff     <= 1'b0;
    end else if (clk_en) begin
      l1_lat_ff  <= common_clock_config ? L1_LAT_COMMON
                                        : L1_LAT_ASYNC;
      l0s_lat_ff <= common_clock_config ? L0S_LAT_COMMON
                                        : L0S_LAT_ASYNC;
      frt_ff     <= frt_hit;
      ack_ff     <= cfg_req;
      rdata_ff   <= (cfg_req && !cfg_we) ? rd_mux : 32'h0000_0000;
      rlim_ff    <= rlim_nxt;
      nsa_ff     <= ctl_ff.no_snoop_enable && tlp_vc_nonzero;
    end
  end

  assign ctl_out           = ctl_ff;
  assign function_reset    = frt_ff;
  assign cfg_ack           = ack_ff;
  assign cfg_rdata         = rdata_ff;
  assign read_limit_bytes  = rlim_ff;
  assign tlp_no_snoop_attr = nsa_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_frt_write;
    clk_en && frt_hit;
  endsequence
  sequence s_frt_done;
    function_reset ##1 (ctl_out.no_snoop_enable && !function_reset);
  endsequence
  property p_frt;
    s_frt_write |=> s_frt_done;
  endproperty
  a_frt: assert property (p_frt) else $error("no function reset");
  property p_frt_read;
    clk_en && hit_ctl && !cfg_we |=> !cfg_rdata[15];
  endproperty
  a_frt_read: assert property (p_frt_read)
    else $error("trigger bit read one");
  property p_rlim;
    clk_en && (rrs == 3'h3) |=> read_limit_bytes == 13'h0400;
  endproperty
  a_rlim: assert property (p_rlim) else $error("bad size cap");
  property p_nsa;
    clk_en |=> tlp_no_snoop_attr ==
      ($past(ctl_ff.no_snoop_enable) && $past(tlp_vc_nonzero));
  endproperty
  a_nsa: assert property (p_nsa) else $error("bad no snoop");
  property p_aux_keep;
    clk_en && func_clr |=> $stable(ctl_out.aux_power_pm_enable);
  endproperty
  a_aux_keep: assert property (p_aux_keep)
    else $error("aux pm lost");
  property p_sts_rsvd;
    clk_en && hit_ctl && !cfg_we |=> cfg_rdata[31:22] == 10'h000
                                     && !cfg_rdata[9];
  endproperty
  a_sts_rsvd: assert property (p_sts_rsvd)
    else $error("reserved read one");
  property p_aux_pin;
    clk_en [*3] |-> aux_s2_ff == $past(aux_power_sense_pin, 2);
  endproperty
  a_aux_pin: assert property (p_aux_pin) else $error("aux lag");
  property p_err_set;
    clk_en && err_event.fatal_error_detected && !func_clr
      |=> err_ff.fatal_error_detected [*1];
  endproperty
  a_err_set: assert property (p_err_set) else $error("flag lost");
  property p_lcap;
    clk_en && hit_lcap && !cfg_we |=>
      (cfg_rdata & 32'hfffc_8fff) == `PDCS_LCAP_FIXED;
  endproperty
  a_lcap: assert property (p_lcap) else $error("bad link caps");
  property p_outstanding_request_flag;
    clk_en && np_issue && !np_done && !func_clr |=> outstanding_request_flag_flag;
  endproperty
  a_outstanding_request_flag: assert property (p_outstanding_request_flag) else $error("pending missing");

endmodule : pdcs_regs

/* pdcs_rc_model.sv */
// root complex model that issues configuration reads and writes
`timescale 1ns/10ps
module pdcs_rc_model (
  // clock
  input  wire logic        clock,
  // request side
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // answer side
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata
);
  // ****************************************
  // access engine
  // ****************************************
  // idle lines: address, enables and data go to the inverse of the last value so a stale copy never matches
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // one dword per access; rd stays unknown if no answer comes
  task automatic access(input logic we, input logic [7:0] adr,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] rd);
    int   n;
    logic got;
    @(posedge clock);
    #2;
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = adr;
    cfg_be    = be;
    cfg_wdata = wd;
    @(posedge clock);
    #2;
    cfg_req   = 1'b0;
    cfg_addr  = ~adr;
    cfg_be    = ~be;
    cfg_wdata = ~wd;
    got       = 1'b0;
    rd        = 32'hxxxx_xxxx;
    for (n = 0; n < 4; n++) begin
      if (!got && cfg_ack === 1'b1) begin
        got = 1'b1;
        rd  = cfg_rdata;
      end
      if (!got) begin
        @(posedge clock);
        #2;
      end
    end
  endtask : access
endmodule : pdcs_rc_model

/* tb.sv */
// self-checking bench of the device control and status bank
`timescale 1ns/10ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb;
  // ****************************************
  // signals
  // ****************************************
  logic                clock, rst_b, cfg_req, cfg_we, cfg_ack;
  logic [7:0]          cfg_addr;
  logic [3:0]          cfg_be;
  logic [31:0]         cfg_wdata, cfg_rdata, d;
  pdcs_pkg::pdcs_err_s err_ev;            // core error pulses
  pdcs_pkg::pdcs_ctl_s ctl_out;           // live control copy
  logic                np_issue, np_done, vc_nz, ccc, aux_pin;
  logic                frst, ns_attr;
  logic                cke;               // clock enable of the bank
  logic [12:0]         lim_bytes;
  int                  n_fail, tests_run;
  // 25 ns clock
  always #12.5 clock = ~clock;
  pdcs_rc_model i_rc (.clock(clock), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  pdcs_regs i_dut (.clock(clock), .rst_b(rst_b), .clk_en(cke),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .err_event(err_ev), .np_issue(np_issue),
    .np_done(np_done), .tlp_vc_nonzero(vc_nz), .common_clock_config(ccc),
    .aux_power_sense_pin(aux_pin), .ctl_out(ctl_out),
    .function_reset(frst), .read_limit_bytes(lim_bytes),
    .tlp_no_snoop_attr(ns_attr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] v);
    logic [31:0] x;
    i_rc.access(1'b1, a, be, v, x);
  endtask : wr
  task automatic give_verdict;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals;
    // aux bit lags the pin by two edges after reset
    cyc(2);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("dword 78", 32'h0010_2810, d);
    `CHK("ctl_out", 14'h1410, ctl_out);
    `CHK("limit", 13'h0200, lim_bytes);
    i_rc.access(1'b0, 8'h7c, 4'hf, 32'h0000_0000, d);
    `CHK("link caps", 32'h0007_1c12, d);
  endtask : t_reset_vals
  // all stored fields, fixed zero bits, then every size code
  task automatic t_ctl_fields;
    wr(8'h78, 4'h3, 32'hffff_7fff);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("ctl all ones", 32'h0010_7dff, d);
    `CHK("ctl_out ones", 14'h3fff, ctl_out);
    for (int c = 0; c < 8; c++) begin
      wr(8'h78, 4'h3, {17'h0_0000, c[2:0], 12'h000});
      cyc(2);
      `CHK("limit", c < 6 ? 13'h0080 << c : 13'h1000, lim_bytes);
    end
  endtask : t_ctl_fields
  task automatic t_no_snoop;
    wr(8'h78, 4'h3, 32'h0000_0800);
    vc_nz = 1'b1;
    cyc(2);
    `CHK("attr vc1", 1'b1, ns_attr);
    vc_nz = 1'b0;
    cyc(2);
    `CHK("attr vc0", 1'b0, ns_attr);
    wr(8'h78, 4'h3, 32'h0000_0000);
    vc_nz = 1'b1;
    cyc(2);
    `CHK("attr off", 1'b0, ns_attr);
    vc_nz = 1'b0;
  endtask : t_no_snoop
  // function reset keeps aux enable, only global reset clears it
  task automatic t_flr;
    wr(8'h78, 4'h3, 32'h0000_8400);
    `CHK("flr pulse", 1'b1, frst);
    cyc(2);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("after flr", 32'h0010_2c10, d);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(3);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("after global", 32'h0010_2810, d);
  endtask : t_flr
  task automatic t_status;
    err_ev   = 4'hf;
    np_issue = 1'b1;
    cyc(1);
    err_ev   = 4'h0;
    np_issue = 1'b0;
    cyc(2);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("errors set", 32'h0030_2810 | 32'h000f_0000, d);
    wr(8'h78, 4'h4, 32'hffc5_0000);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("w1c", 32'h003a_2810, d);
    np_done = 1'b1;
    aux_pin = 1'b0;
    cyc(1);
    np_done = 1'b0;
    cyc(4);
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("outstanding_request_flag aux", 32'h000a_2810, d);
    // an issue seen only on frozen edges must not be counted
    cke      = 1'b0;
    np_issue = 1'b1;
    cyc(1);
    np_issue = 1'b0;
    cke      = 1'b1;
    i_rc.access(1'b0, 8'h78, 4'hf, 32'h0000_0000, d);
    `CHK("frozen", 32'h000a_2810, d);
  endtask : t_status
  task automatic t_link;
    wr(8'h7c, 4'hf, 32'h0000_0000);
    i_rc.access(1'b0, 8'h7c, 4'hf, 32'h0000_0000, d);
    `CHK("caps kept", 32'h0007_1c12, d);
    ccc = 1'b1;
    cyc(2);
    i_rc.access(1'b0, 8'h7c, 4'hf, 32'h0000_0000, d);
    `CHK("caps common", 32'h0007_3c12, d);
    i_rc.access(1'b0, 8'h40, 4'hf, 32'h0000_0000, d);
    `CHK("unmapped", 32'h0000_0000, d);
  endtask : t_link
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {clock, rst_b, np_issue, np_done, vc_nz, ccc} = 6'h00;
    n_fail    = 0;
    tests_run = 0;
    cke       = 1'b1;
    err_ev  = 4'h0;
    aux_pin = 1'b1;
    repeat (12) @(posedge clock);
    #2;
    rst_b = 1'b1;
    t_reset_vals();
    t_ctl_fields();
    t_no_snoop();
    t_flr();
    t_status();
    t_link();
    give_verdict();
  end
  // about 100 cycles expected; far longer means a hang
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
endmodule : tb
